// >>> src/frs_cmd.sv
// Purpose: Command interpreter for frame read, partial rows, tearing sync and scan order
// Assumes: Display bus pins are asynchronous; timing and memory ports share pclk
// Notes: Frame memory returns data the cycle after it sees mem_rd_en high
`timescale 1ns/1ps
module frs_cmd
  import frs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Display command bus pins
  input wire logic cmd_param_select,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [23:0] db_in,
  output logic [23:0] db_out,
  output logic db_oe,
  // Frame memory read port
  output logic mem_rd_en,
  output logic [9:0] mem_col,
  output logic [9:0] mem_page,
  input wire logic [23:0] mem_rdata,
  // Display timing inputs
  input wire logic frame_start,
  input wire logic porch_blank,
  input wire logic hblank,
  input wire logic [9:0] scan_row,
  input wire logic partial_mode_on,
  input wire logic sleep_mode,
  // Panel side outputs
  output logic frame_sync_output,
  output frs_scan_t scan_order,
  output frs_window_t partial_rows
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int unsigned SW = FRS_DW + 3;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic [SW-1:0] sync3_reg;
  logic wr_event;
  logic rd_start;
  logic rd_end;
  logic is_param;
  logic [23:0] bus_data;
  logic [1:0] ctrl_reg;
  frs_window_t col_win_reg;
  frs_window_t page_win_reg;
  logic [7:0] cmd_reg;
  logic [1:0] param_idx_reg;
  frs_scan_t scan_reg;
  frs_window_t part_reg;
  logic [1:0] part_hi_reg;
  logic sync_on_reg;
  logic sync_was_on_reg;
  logic mode_pending_reg;
  logic mode_active_reg;
  logic sync_out_reg;
  frs_rd_state_t rd_state_reg;
  logic rd_active_reg;
  logic dummy_reg;
  logic [1:0] byte_idx_reg;
  logic [9:0] col_off_reg;
  logic [9:0] page_off_reg;
  logic [23:0] pix_reg;
  logic mem_rd_en_reg;
  logic [9:0] mem_col_reg;
  logic [9:0] mem_page_reg;
  logic [23:0] db_out_reg;
  logic db_oe_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [9:0] col_span;
  logic [9:0] page_span;
  logic col_at_end;
  logic page_at_end;
  logic at_last;
  logic [9:0] phys_col;
  logic [9:0] phys_page;
  logic new_cmd;
  logic in_partial;
  logic vblank;
  logic apb_access;
  logic [31:0] rd_mux;
  logic addr_hit;

  // ----------------------------------------------------------------
  // Pin synchronisers: three stages, edges from stages two and three
  // ----------------------------------------------------------------
  // Strobes idle high, so their stages reset high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= {3'h7, 24'h000000};
      sync2_reg <= {3'h7, 24'h000000};
      sync3_reg <= {3'h7, 24'h000000};
    end else begin
      sync1_reg <= {cmd_param_select, write_strobe_n, read_strobe_n, db_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Write taken on rising strobe; read begins on falling strobe
  assign wr_event = sync2_reg[SW-2] && !sync3_reg[SW-2];
  assign rd_start = !sync2_reg[SW-3] && sync3_reg[SW-3];
  assign rd_end = sync2_reg[SW-3] && !sync3_reg[SW-3];
  assign is_param = sync2_reg[SW-1];
  assign bus_data = sync2_reg[FRS_DW-1:0];
  assign new_cmd = wr_event && !is_param;

  // ----------------------------------------------------------------
  // Command and parameter decode
  // ----------------------------------------------------------------
  // Latch command code and count its parameters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 8'h00;
      param_idx_reg <= 2'h0;
    end else if (new_cmd) begin
      cmd_reg <= bus_data[7:0];
      param_idx_reg <= 2'h0;
    end else if (wr_event && param_idx_reg != 2'h3) begin
      param_idx_reg <= param_idx_reg + 2'h1;
    end
  end

  // Scan-order setting, reserved bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_reg <= frs_scan_t'(5'h00);
    end else if (wr_event && is_param && cmd_reg == FRS_CMD_SCAN && param_idx_reg == 2'h0) begin
      scan_reg.page_order_bit <= bus_data[FRS_SCAN_PAGE_POS];
      scan_reg.column_order_bit <= bus_data[FRS_SCAN_COL_POS];
      scan_reg.row_column_swap_bit <= bus_data[FRS_SCAN_SWAP_POS];
      scan_reg.color_order_bit <= bus_data[FRS_SCAN_COLOR_POS];
      scan_reg.vertical_flip_bit <= bus_data[FRS_SCAN_FLIP_POS];
    end
  end

  // Partial rows: upper bits held until the lower byte completes a row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part_reg <= {FRS_ROW_RESET, FRS_ROW_RESET};
      part_hi_reg <= 2'h0;
    end else if (wr_event && is_param && cmd_reg == FRS_CMD_PARTIAL) begin
      case (param_idx_reg)
        2'h0, 2'h2: begin
          part_hi_reg <= bus_data[1:0] & FRS_HI_MASK;
        end
        2'h1: begin
          part_reg.first <= {part_hi_reg, bus_data[7:0]};
        end
        2'h3: begin
          part_reg.last <= {part_hi_reg, bus_data[7:0]};
        end
        default: begin
          part_hi_reg <= part_hi_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Tearing-sync control
  // ----------------------------------------------------------------
  // Enable, disable and line mode staging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_on_reg <= 1'b0;
      sync_was_on_reg <= 1'b0;
      mode_pending_reg <= 1'b0;
    end else if (new_cmd && bus_data[7:0] == FRS_CMD_SYNC_OFF) begin
      sync_on_reg <= 1'b0;
    end else if (new_cmd && bus_data[7:0] == FRS_CMD_SYNC_ON) begin
      sync_was_on_reg <= sync_on_reg;
    end else if (wr_event && is_param && cmd_reg == FRS_CMD_SYNC_ON && param_idx_reg == 2'h0) begin
      if (!sync_was_on_reg) begin
        sync_on_reg <= 1'b1;
        mode_pending_reg <= bus_data[0];
      end
    end
  end

  // Line mode takes effect at the frame boundary only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_active_reg <= 1'b0;
    end else if (frame_start) begin
      mode_active_reg <= mode_pending_reg;
    end
  end

  // Row inside partial window, wrapping when last is below first
  always_comb begin
    if (part_reg.first <= part_reg.last) begin
      in_partial = scan_row >= part_reg.first && scan_row <= part_reg.last;
    end else begin
      in_partial = scan_row >= part_reg.first || scan_row <= part_reg.last;
    end
  end

  assign vblank = porch_blank || (partial_mode_on && !in_partial);

  // Sync output level, forced low in sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out_reg <= 1'b0;
    end else if (sleep_mode || !sync_on_reg) begin
      sync_out_reg <= 1'b0;
    end else begin
      sync_out_reg <= vblank || (mode_active_reg && hblank);
    end
  end

  // ----------------------------------------------------------------
  // Address counters for the read stream
  // ----------------------------------------------------------------
  assign col_span = col_win_reg.last - col_win_reg.first;
  assign page_span = page_win_reg.last - page_win_reg.first;
  assign col_at_end = col_off_reg == col_span;
  assign page_at_end = page_off_reg == page_span;
  assign at_last = col_at_end && page_at_end;
  // Direction bits mirror the offset inside the window
  assign phys_col = scan_reg.column_order_bit ? col_win_reg.last - col_off_reg
                                               : col_win_reg.first + col_off_reg;
  assign phys_page = scan_reg.page_order_bit ? page_win_reg.last - page_off_reg
                                              : page_win_reg.first + page_off_reg;

  // Offsets load on the read command and step after each whole pixel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_off_reg <= 10'h000;
      page_off_reg <= 10'h000;
    end else if (new_cmd && bus_data[7:0] == FRS_CMD_READ_MEM) begin
      col_off_reg <= 10'h000;
      page_off_reg <= 10'h000;
    end else if (rd_active_reg && rd_end && !dummy_reg && !at_last &&
                 (!ctrl_reg[FRS_CTRL_NARROW_POS] || byte_idx_reg == FRS_LAST_BYTE)) begin
      if (!scan_reg.row_column_swap_bit) begin
        col_off_reg <= col_at_end ? 10'h000 : col_off_reg + 10'h001;
        page_off_reg <= col_at_end ? page_off_reg + 10'h001 : page_off_reg;
      end else begin
        page_off_reg <= page_at_end ? 10'h000 : page_off_reg + 10'h001;
        col_off_reg <= page_at_end ? col_off_reg + 10'h001 : col_off_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read stream sequencer
  // ----------------------------------------------------------------
  // Fetch a pixel, then wait for the host to read it out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_state_reg <= FRS_RD_IDLE;
      rd_active_reg <= 1'b0;
      dummy_reg <= 1'b0;
      byte_idx_reg <= 2'h0;
    end else if (new_cmd) begin
      rd_active_reg <= bus_data[7:0] == FRS_CMD_READ_MEM;
      rd_state_reg <= bus_data[7:0] == FRS_CMD_READ_MEM ? FRS_RD_ISSUE : FRS_RD_IDLE;
      dummy_reg <= !ctrl_reg[FRS_CTRL_SERIAL_POS];
      byte_idx_reg <= 2'h0;
    end else begin
      case (rd_state_reg)
        FRS_RD_IDLE: begin
          rd_state_reg <= FRS_RD_IDLE;
        end
        FRS_RD_ISSUE: begin
          rd_state_reg <= FRS_RD_WAIT;
        end
        FRS_RD_WAIT: begin
          rd_state_reg <= FRS_RD_CAPT;
        end
        FRS_RD_CAPT: begin
          rd_state_reg <= FRS_RD_READY;
        end
        FRS_RD_READY: begin
          if (rd_end && dummy_reg) begin
            dummy_reg <= 1'b0;
          end else if (rd_end && ctrl_reg[FRS_CTRL_NARROW_POS] && byte_idx_reg != FRS_LAST_BYTE) begin
            byte_idx_reg <= byte_idx_reg + 2'h1;
          end else if (rd_end) begin
            byte_idx_reg <= 2'h0;
            rd_state_reg <= at_last ? FRS_RD_READY : FRS_RD_ISSUE;
          end
        end
        default: begin
          rd_state_reg <= FRS_RD_IDLE;
        end
      endcase
    end
  end

  // Memory request and pixel capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rd_en_reg <= 1'b0;
      mem_col_reg <= 10'h000;
      mem_page_reg <= 10'h000;
      pix_reg <= 24'h000000;
    end else begin
      mem_rd_en_reg <= rd_state_reg == FRS_RD_ISSUE && !new_cmd;
      if (rd_state_reg == FRS_RD_ISSUE) begin
        mem_col_reg <= phys_col;
        mem_page_reg <= phys_page;
      end
      if (rd_state_reg == FRS_RD_CAPT) begin
        pix_reg <= mem_rdata;
      end
    end
  end

  // Drive the data bus while the host holds its read strobe low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_out_reg <= 24'h000000;
      db_oe_reg <= 1'b0;
    end else if (rd_start) begin
      db_oe_reg <= 1'b1;
      if (!rd_active_reg || dummy_reg) begin
        db_out_reg <= 24'h000000;
      end else if (!ctrl_reg[FRS_CTRL_NARROW_POS]) begin
        db_out_reg <= pix_reg;
      end else begin
        case (byte_idx_reg)
          2'h0: db_out_reg <= {16'h0000, pix_reg[23:16]};
          2'h1: db_out_reg <= {16'h0000, pix_reg[15:8]};
          default: db_out_reg <= {16'h0000, pix_reg[7:0]};
        endcase
      end
    end else if (rd_end) begin
      db_oe_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, registered answer
  // ----------------------------------------------------------------
  assign apb_access = psel && penable && !pready_reg;

  // Address decode and read data
  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      FRS_OFS_CTRL: rd_mux = {30'h00000000, ctrl_reg};
      FRS_OFS_COL_WIN: rd_mux = {6'h00, col_win_reg.last, 6'h00, col_win_reg.first};
      FRS_OFS_PAGE_WIN: rd_mux = {6'h00, page_win_reg.last, 6'h00, page_win_reg.first};
      FRS_OFS_STATUS: rd_mux = {16'h0000, 3'h0, scan_reg, 3'h0, rd_active_reg,
                                mode_pending_reg, mode_active_reg, sync_out_reg, sync_on_reg};
      FRS_OFS_PARTIAL: rd_mux = {6'h00, part_reg.last, 6'h00, part_reg.first};
      default: addr_hit = 1'b0;
    endcase
  end

  // Writable configuration, committed at the edge that completes the transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= FRS_CTRL_RESET;
      col_win_reg <= {FRS_WIN_START_RESET, FRS_WIN_END_RESET};
      page_win_reg <= {FRS_WIN_START_RESET, FRS_WIN_END_RESET};
    end else if (psel && penable && pready_reg && pwrite) begin
      case (paddr)
        FRS_OFS_CTRL: ctrl_reg <= pwdata[1:0];
        FRS_OFS_COL_WIN: col_win_reg <= {pwdata[9:0], pwdata[FRS_WIN_END_POS +: FRS_AW]};
        FRS_OFS_PAGE_WIN: page_win_reg <= {pwdata[9:0], pwdata[FRS_WIN_END_POS +: FRS_AW]};
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apb_access;
      pslverr_reg <= apb_access && !addr_hit;
      prdata_reg <= (apb_access && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign db_out = db_out_reg;
  assign db_oe = db_oe_reg;
  assign mem_rd_en = mem_rd_en_reg;
  assign mem_col = mem_col_reg;
  assign mem_page = mem_page_reg;
  assign frame_sync_output = sync_out_reg;
  assign scan_order = scan_reg;
  assign partial_rows = part_reg;

endmodule : frs_cmd

// >>> src/frs_pkg.sv
// Purpose: Shared constants and types for the frame read, sync and scan command block
// Assumes: 24-bit display data bus, 10-bit row and column addresses, APB with 32-bit data
// Notes: Command codes, register offsets and scan and control bit positions used by the command block are named here once
package frs_pkg;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FRS_CMD_READ_MEM = 8'h2E;
  localparam logic [7:0] FRS_CMD_PARTIAL = 8'h30;
  localparam logic [7:0] FRS_CMD_SYNC_OFF = 8'h34;
  localparam logic [7:0] FRS_CMD_SYNC_ON = 8'h35;
  localparam logic [7:0] FRS_CMD_SCAN = 8'h36;
  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FRS_AW = 10;
  localparam int unsigned FRS_DW = 24;
  localparam logic [7:0] FRS_SCAN_RESET = 8'h00;
  localparam logic [1:0] FRS_HI_MASK = 2'h3;
  localparam logic [9:0] FRS_ROW_RESET = 10'h000;
  localparam logic [9:0] FRS_WIN_START_RESET = 10'h000;
  localparam logic [9:0] FRS_WIN_END_RESET = 10'h000;
  localparam int unsigned FRS_SCAN_PAGE_POS = 7;
  localparam int unsigned FRS_SCAN_COL_POS = 6;
  localparam int unsigned FRS_SCAN_SWAP_POS = 5;
  localparam int unsigned FRS_SCAN_COLOR_POS = 3;
  localparam int unsigned FRS_SCAN_FLIP_POS = 0;
  localparam int unsigned FRS_WIN_END_POS = 16;
  localparam logic [1:0] FRS_LAST_BYTE = 2'h2;
  // ----------------------------------------------------------------
  // APB register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] FRS_OFS_CTRL = 12'h000;
  localparam logic [11:0] FRS_OFS_COL_WIN = 12'h004;
  localparam logic [11:0] FRS_OFS_PAGE_WIN = 12'h008;
  localparam logic [11:0] FRS_OFS_STATUS = 12'h00C;
  localparam logic [11:0] FRS_OFS_PARTIAL = 12'h010;
  localparam int unsigned FRS_CTRL_SERIAL_POS = 0;
  localparam int unsigned FRS_CTRL_NARROW_POS = 1;
  localparam logic [1:0] FRS_CTRL_RESET = 2'h0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic page_order_bit;
    logic column_order_bit;
    logic row_column_swap_bit;
    logic color_order_bit;
    logic vertical_flip_bit;
  } frs_scan_t;
  typedef struct packed {
    logic [9:0] first;
    logic [9:0] last;
  } frs_window_t;
  typedef enum logic [2:0] {
    FRS_RD_IDLE,
    FRS_RD_ISSUE,
    FRS_RD_WAIT,
    FRS_RD_CAPT,
    FRS_RD_READY
  } frs_rd_state_t;
endpackage : frs_pkg

// >>> verification/frs_cmd_monitor.sv
// Purpose: Port assertions for the frame read, sync and scan command block
// Assumes: The APB master holds each request until pready is sampled high
// Notes: Bound to frs_cmd from the bench top file
`timescale 1ns/1ps
module frs_cmd_monitor
  import frs_pkg::*;
(
  // Clock, reset and watched inputs
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic read_strobe_n,
  input wire logic porch_blank,
  input wire logic hblank,
  input wire logic partial_mode_on,
  input wire logic sleep_mode,
  // Watched outputs
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic db_oe,
  input wire logic mem_rd_en,
  input wire logic [9:0] mem_col,
  input wire logic [9:0] mem_page,
  input wire logic frame_sync_output
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Register bus answer
  // ----------------------------------------------------------------
  property p_ans; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_ans: assert property (p_ans) else $error("pready not a single pulse after access");
  property p_err; psel && penable && pready |-> pslverr == (paddr > FRS_OFS_PARTIAL); endproperty
  a_err: assert property (p_err) else $error("pslverr does not match address map");
  property p_rdz; !pready |-> prdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("prdata not zero outside answer");
  // ----------------------------------------------------------------
  // Frame read path
  // ----------------------------------------------------------------
  property p_mem; mem_rd_en |=> !mem_rd_en && $stable(mem_col) && $stable(mem_page); endproperty
  a_mem: assert property (p_mem) else $error("memory request not a stable pulse");
  property p_drive; !read_strobe_n [*5] |-> db_oe; endproperty
  a_drive: assert property (p_drive) else $error("bus not driven during read");
  property p_release; read_strobe_n [*5] |-> !db_oe; endproperty
  a_release: assert property (p_release) else $error("bus still driven after read");
  // ----------------------------------------------------------------
  // Tearing sync output
  // ----------------------------------------------------------------
  property p_sleep; sleep_mode && $past(sleep_mode) |-> !frame_sync_output; endproperty
  a_sleep: assert property (p_sleep) else $error("sync output high in sleep");
  property p_cause; frame_sync_output |-> $past(porch_blank || hblank || partial_mode_on); endproperty
  a_cause: assert property (p_cause) else $error("sync output high outside blanking");
endmodule : frs_cmd_monitor

// >>> verification/frs_mem_model.sv
// Purpose: Frame memory model answering the command block's read port
// Assumes: Data is due the cycle after a one-cycle request
// Notes: Pixel value encodes its own page and column
`timescale 1ns/1ps
module frs_mem_model
  import frs_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Read port
  input wire logic mem_rd_en,
  input wire logic [9:0] mem_col,
  input wire logic [9:0] mem_page,
  output logic [23:0] mem_rdata = 24'h5A5A5A
);
  // Answer a request next cycle; stale data toggles so it cannot pass for valid
  always @(posedge pclk) begin
    if (mem_rd_en) begin
      mem_rdata <= {4'hA, mem_page, mem_col};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : frs_mem_model

// >>> verification/frs_cmd_bench.sv
// Purpose: Self-checking bench for the frame read, sync and scan command block
// Assumes: Column window 2..3, page window 5..6 set over APB
// Notes: Drivers queue expected results; monitors pop and compare
`timescale 1ns/1ps
module frs_cmd_bench
  import frs_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, db_oe, mem_rd_en, frame_sync_output, oe_d = 0;
  logic cmd_param_select = 0, write_strobe_n = 1, read_strobe_n = 1, frame_start = 0;
  logic porch_blank = 0, hblank = 0, partial_mode_on = 0, sleep_mode = 0;
  logic [23:0] db_in = '0, db_out, mem_rdata;
  logic [9:0] mem_col, mem_page, scan_row = '0;
  logic [7:0] sc;
  logic [7:0] modes [5] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'hC0};
  frs_scan_t scan_order;
  frs_window_t partial_rows;
  logic [31:0] apb_q[$];
  logic [23:0] pix_q[$];
  int n_errors = 0, n_compared = 0, cycles = 0;
  // ----------------------------------------------------------------
  // Design, memory and clock
  // ----------------------------------------------------------------
  frs_cmd i_frs_cmd (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .cmd_param_select, .write_strobe_n, .read_strobe_n, .db_in, .db_out, .db_oe,
    .mem_rd_en, .mem_col, .mem_page, .mem_rdata, .frame_start, .porch_blank, .hblank, .scan_row,
    .partial_mode_on, .sleep_mode, .frame_sync_output, .scan_order, .partial_rows);
  frs_mem_model i_frs_mem_model (.pclk, .mem_rd_en, .mem_col, .mem_page, .mem_rdata);
  always #5 pclk = ~pclk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic results;
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    if (!wr) apb_q.push_back(e);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic pin_wr(input logic dc, input logic [7:0] b);
    cmd_param_select <= dc;
    db_in <= {16'h0, b};
    write_strobe_n <= 0;
    repeat (5) @(posedge pclk);
    write_strobe_n <= 1;
    repeat (9) @(posedge pclk);
  endtask : pin_wr
  task automatic pin_rd(input logic [23:0] e);
    pix_q.push_back(e);
    read_strobe_n <= 0;
    repeat (6) @(posedge pclk);
    read_strobe_n <= 1;
    repeat (10) @(posedge pclk);
  endtask : pin_rd
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // Pixel expected at read k for scan byte s
  function automatic logic [23:0] pix(input logic [7:0] s, input int k);
    int i, c, p;
    i = (k > 3) ? 3 : k;
    c = s[5] ? i / 2 : i % 2;
    p = s[5] ? i % 2 : i / 2;
    return {4'hA, 10'(s[7] ? 6 - p : 5 + p), 10'(s[6] ? 3 - c : 2 + c)};
  endfunction : pix
  // ----------------------------------------------------------------
  // Monitors and timeout
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && pready && !pwrite) cmp(prdata, apb_q.pop_front());
    if (db_oe && !oe_d) cmp(db_out, pix_q.pop_front());
    oe_d = db_oe;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(79834));
    tick(3);
    presetn <= 1;
    tick(1);
    apb(0, FRS_OFS_STATUS, 0, 32'h0);
    apb(0, 12'h020, 0, 32'h0);
    apb(1, FRS_OFS_COL_WIN, {6'h0, 10'd3, 6'h0, 10'd2}, 0);
    apb(1, FRS_OFS_PAGE_WIN, {6'h0, 10'd6, 6'h0, 10'd5}, 0);
    apb(0, FRS_OFS_PAGE_WIN, 0, {6'h0, 10'd6, 6'h0, 10'd5});
    // Random scan byte reaches the panel outputs and status
    sc = 8'($urandom()) & 8'hE9;
    pin_wr(0, FRS_CMD_SCAN);
    pin_wr(1, sc);
    cmp(scan_order, {sc[7], sc[6], sc[5], sc[3], sc[0]});
    apb(0, FRS_OFS_STATUS, 0, {19'h0, sc[7], sc[6], sc[5], sc[3], sc[0], 8'h0});
    // Read streams in each direction; last pass on the serial link
    for (int m = 0; m < 5; m++) begin
      apb(1, FRS_OFS_CTRL, 32'(m == 4), 0);
      pin_wr(0, FRS_CMD_SCAN);
      pin_wr(1, modes[m]);
      pin_wr(0, FRS_CMD_READ_MEM);
      if (m != 4) pin_rd(24'h0);
      for (int k = 0; k < 6; k++) pin_rd(pix(modes[m], k));
    end
    // Narrow reads: three bytes per pixel, high byte first
    apb(1, FRS_OFS_CTRL, 32'h2, 0);
    pin_wr(0, FRS_CMD_READ_MEM);
    pin_rd(24'h0);
    for (int b = 2; b >= 0; b--) pin_rd({16'h0, 8'(pix(8'hC0, 0) >> (8 * b))});
    pin_rd({16'h0, 8'(pix(8'hC0, 1) >> 16)});
    // Another command cuts a stream short
    apb(1, FRS_OFS_CTRL, 0, 0);
    pin_wr(0, FRS_CMD_READ_MEM);
    pin_rd(24'h0);
    pin_rd(pix(8'hC0, 0));
    pin_wr(0, FRS_CMD_SYNC_OFF);
    pin_rd(24'h0);
    // Partial rows with junk in the upper bytes
    pin_wr(0, FRS_CMD_PARTIAL);
    pin_wr(1, 8'hFD);
    pin_wr(1, 8'h23);
    pin_wr(1, 8'hFC);
    pin_wr(1, 8'h45);
    cmp(partial_rows, {10'h123, 10'h045});
    apb(0, FRS_OFS_PARTIAL, 0, {6'h0, 10'h045, 6'h0, 10'h123});
    // Sync output modes, reissue, off and sleep
    pin_wr(0, FRS_CMD_SYNC_ON);
    pin_wr(1, 8'h00);
    hblank <= 1;
    tick(3);
    cmp(frame_sync_output, 0);
    porch_blank <= 1;
    tick(3);
    cmp(frame_sync_output, 1);
    // Partial mode: rows outside the wrapped window count as blanking
    porch_blank <= 0;
    partial_mode_on <= 1;
    scan_row <= 10'h100;
    tick(3);
    cmp(frame_sync_output, 1);
    scan_row <= 10'($urandom_range(69));
    tick(3);
    cmp(frame_sync_output, 0);
    partial_mode_on <= 0;
    porch_blank <= 1;
    pin_wr(0, FRS_CMD_SYNC_ON);
    pin_wr(1, 8'h01);
    frame_start <= 1;
    tick(1);
    frame_start <= 0;
    porch_blank <= 0;
    tick(3);
    cmp(frame_sync_output, 0);
    porch_blank <= 1;
    pin_wr(0, FRS_CMD_SYNC_OFF);
    cmp(frame_sync_output, 0);
    porch_blank <= 0;
    pin_wr(0, FRS_CMD_SYNC_ON);
    pin_wr(1, 8'h01);
    cmp(frame_sync_output, 0);
    frame_start <= 1;
    tick(1);
    frame_start <= 0;
    tick(3);
    cmp(frame_sync_output, 1);
    sleep_mode <= 1;
    tick(3);
    cmp(frame_sync_output, 0);
    results();
  end
endmodule : frs_cmd_bench
bind frs_cmd frs_cmd_monitor i_frs_cmd_monitor (.pclk, .presetn, .paddr, .psel, .penable, .read_strobe_n,
  .porch_blank, .hblank, .partial_mode_on, .sleep_mode, .prdata, .pready, .pslverr, .db_oe, .mem_rd_en,
  .mem_col, .mem_page, .frame_sync_output);
